// ==== verilog/tccs_pkg.sv ====
// Purpose: constants and carrier types for the timer flag/control block
// Assumes: 10 MHz clk_sys, synchronous active-high reset
// Notes:   register indices are word indices on the block's own register port
package tccs_pkg;

    localparam int DATA_W = 16;

    // register word indices
    localparam logic [3:0] ADDR_FLAG = 4'h0;
    localparam logic [3:0] ADDR_TCTL = 4'h1;
    localparam logic [3:0] ADDR_IEN  = 4'h2;
    localparam logic [3:0] ADDR_CNT  = 4'h3;
    localparam logic [3:0] ADDR_CMPA = 4'h4;
    localparam logic [3:0] ADDR_CMPB = 4'h5;
    localparam logic [3:0] ADDR_CAPA = 4'h6;
    localparam logic [3:0] ADDR_CAPB = 4'h7;
    localparam logic [3:0] ADDR_CAPC = 4'h8;
    localparam logic [3:0] ADDR_CAPD = 4'h9;

    // timer_flag_control field positions
    localparam int BIT_CAPF_A = 7;
    localparam int BIT_CAPF_B = 6;
    localparam int BIT_CAPF_C = 5;
    localparam int BIT_CAPF_D = 4;
    localparam int BIT_CMPF_A = 3;
    localparam int BIT_CMPF_B = 2;
    localparam int BIT_OVF    = 1;
    localparam int BIT_CLR_A  = 0;

    // timer_control field positions
    localparam int BIT_EDGE_A = 7;
    localparam int BIT_EDGE_B = 6;
    localparam int BIT_EDGE_C = 5;
    localparam int BIT_EDGE_D = 4;
    localparam int BIT_BUF_A  = 3;
    localparam int BIT_BUF_B  = 2;

    // reset values
    localparam logic [7:0]  FLAG_RST = 8'h00;
    localparam logic [7:0]  TCTL_RST = 8'h00;
    localparam logic [7:0]  IEN_RST  = 8'h01;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CMP_RST  = 16'hFFFF;
    localparam logic [15:0] CAP_RST  = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } tccs_req_t;

    typedef struct packed {
        logic capA;
        logic capB;
        logic capC;
        logic capD;
    } tccs_pins_t;

endpackage : tccs_pkg

// ==== verilog/tccs_timer_status.sv ====
// Purpose: free-running counter with capture/compare flags and control register
// Assumes: counter advances on countTick; capture pins are asynchronous
// Notes:   prescaler, compare output pins and byte-wise access are outside
`timescale 1ns/100ps
`default_nettype none

module tccs_timer_status #(
    parameter int CNT_W = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic                  lowPower,
    input  wire logic                  countTick,
    input  wire tccs_pkg::tccs_req_t   regReq,
    output logic [15:0]                regRdata,
    input  wire tccs_pkg::tccs_pins_t  capPins,
    output logic [7:1]                 irqVec,
    output logic                       irqAny
);
    import tccs_pkg::*;

    if (CNT_W != DATA_W) begin : g_bad_width
        $error("CNT_W must equal the 16-bit register width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic edgeHit(input logic prev, input logic cur,
                                     input logic rising);
        edgeHit = rising ? (cur & ~prev) : (prev & ~cur);
    endfunction : edgeHit

    function automatic logic isWrite(input tccs_req_t req, input logic [3:0] a);
        isWrite = req.wr && (req.addr == a);
    endfunction : isWrite

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic             wipe;
    logic [7:0]       flagCtl_r;
    logic [7:0]       flagCtl_nxt;
    logic [7:1]       armed_r;
    logic [7:1]       armed_nxt;
    logic [7:0]       tctl_r;
    logic [7:1]       ien_r;
    logic [15:0]      cnt_r;
    logic [15:0]      cnt_nxt;
    logic [15:0]      cmpA_r;
    logic [15:0]      cmpB_r;
    logic [15:0]      capA_r;
    logic [15:0]      capB_r;
    logic [15:0]      capC_r;
    logic [15:0]      capD_r;
    logic             eqA_r;
    logic             eqB_r;
    tccs_pins_t       sync1_r;
    tccs_pins_t       sync2_r;
    tccs_pins_t       prev_r;

    logic             eqA;
    logic             eqB;
    logic             matchA;
    logic             matchB;
    logic             clearByMatch;
    logic             overflow;
    logic             evA;
    logic             evB;
    logic             evC;
    logic             evD;
    logic             bufA;
    logic             bufB;
    logic             wrFlag;
    logic             rdFlag;
    logic [7:1]       setVec;
    logic [7:1]       clrVec;
    logic [15:0]      rdVal;

    // standby-type modes behave exactly like reset for every register but the pin chain
    assign wipe = srst | lowPower;

    ////////////////////////////////////////////////////////////////////////////
    // capture pin synchronisers and edge selection

    // the chain keeps sampling through reset: a zeroed chain would report
    // a false edge on a pin that idles high once reset lets go
    always_ff @(posedge clk_sys) begin
        sync1_r <= capPins;
        sync2_r <= sync1_r;
        prev_r  <= sync2_r;
    end

    assign bufA = tctl_r[BIT_BUF_A];
    assign bufB = tctl_r[BIT_BUF_B];

    // buffered A takes the A pin on either edge selection, so unequal
    // selects give both edges while input C stays a plain interrupt source
    always_comb begin
        evA = edgeHit(prev_r.capA, sync2_r.capA, tctl_r[BIT_EDGE_A]);
        if (bufA) begin
            evA = evA | edgeHit(prev_r.capA, sync2_r.capA, tctl_r[BIT_EDGE_C]);
        end
        evB = edgeHit(prev_r.capB, sync2_r.capB, tctl_r[BIT_EDGE_B]);
        if (bufB) begin
            evB = evB | edgeHit(prev_r.capB, sync2_r.capB, tctl_r[BIT_EDGE_D]);
        end
        evC = edgeHit(prev_r.capC, sync2_r.capC, tctl_r[BIT_EDGE_C]);
        evD = edgeHit(prev_r.capD, sync2_r.capD, tctl_r[BIT_EDGE_D]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // running counter and compare

    assign eqA = (cnt_r == cmpA_r);
    assign eqB = (cnt_r == cmpB_r);
    // a match is one event per arrival, not one per cycle of equality
    assign matchA = eqA & ~eqA_r;
    assign matchB = eqB & ~eqB_r;

    assign clearByMatch = countTick & eqA & flagCtl_r[BIT_CLR_A];
    // neither a clear by match nor a software load is counted as an overflow
    assign overflow = countTick & (cnt_r == CNT_MAX) & ~clearByMatch
                    & ~isWrite(regReq, ADDR_CNT);

    always_comb begin
        cnt_nxt = cnt_r;
        if (isWrite(regReq, ADDR_CNT)) begin
            cnt_nxt = regReq.wdata;
        end else if (clearByMatch) begin
            cnt_nxt = CNT_RST;
        end else if (countTick) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            cnt_r <= CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            eqA_r <= 1'b0;
            eqB_r <= 1'b0;
        end else begin
            eqA_r <= eqA;
            eqB_r <= eqB;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            cmpA_r <= CMP_RST;
            cmpB_r <= CMP_RST;
        end else begin
            if (isWrite(regReq, ADDR_CMPA)) begin
                cmpA_r <= regReq.wdata;
            end
            if (isWrite(regReq, ADDR_CMPB)) begin
                cmpB_r <= regReq.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture registers; they load whatever the counter holds, or in buffered mode C/D take the old A/B value

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            capA_r <= CAP_RST;
            capC_r <= CAP_RST;
        end else begin
            if (evA) begin
                capA_r <= cnt_r;
                if (bufA) begin
                    capC_r <= capA_r;
                end
            end
            if (evC && !bufA) begin
                capC_r <= cnt_r;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            capB_r <= CAP_RST;
            capD_r <= CAP_RST;
        end else begin
            if (evB) begin
                capB_r <= cnt_r;
                if (bufB) begin
                    capD_r <= capB_r;
                end
            end
            if (evD && !bufB) begin
                capD_r <= cnt_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag and control register

    assign wrFlag = isWrite(regReq, ADDR_FLAG);
    assign rdFlag = regReq.rd && (regReq.addr == ADDR_FLAG);

    always_comb begin
        setVec             = '0;
        setVec[BIT_CAPF_A] = evA;
        setVec[BIT_CAPF_B] = evB;
        setVec[BIT_CAPF_C] = evC;
        setVec[BIT_CAPF_D] = evD;
        setVec[BIT_CMPF_A] = matchA;
        setVec[BIT_CMPF_B] = matchB;
        setVec[BIT_OVF]    = overflow;
    end

    // only a 0 clears, and only a bit that was seen as 1; a 1 is ignored
    assign clrVec = wrFlag ? (~regReq.wdata[7:1] & armed_r) : '0;

    always_comb begin
        flagCtl_nxt      = flagCtl_r;
        // set applied after clear so a same-cycle event survives
        flagCtl_nxt[7:1] = (flagCtl_r[7:1] & ~clrVec) | setVec;
        if (wrFlag) begin
            flagCtl_nxt[BIT_CLR_A] = regReq.wdata[BIT_CLR_A];
        end
    end

    // arming remembers which flags software has seen as 1
    assign armed_nxt = (armed_r & ~clrVec)
                     | (rdFlag ? flagCtl_r[7:1] : 7'h00);

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            flagCtl_r <= FLAG_RST;
            armed_r   <= '0;
        end else begin
            flagCtl_r <= flagCtl_nxt;
            armed_r   <= armed_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer control and interrupt enables

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            tctl_r <= TCTL_RST;
        end else if (isWrite(regReq, ADDR_TCTL)) begin
            tctl_r <= regReq.wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            ien_r <= IEN_RST[7:1];
        end else if (isWrite(regReq, ADDR_IEN)) begin
            ien_r <= regReq.wdata[7:1];
        end
    end

    assign irqVec = flagCtl_r[7:1] & ien_r;
    assign irqAny = |irqVec;

    ////////////////////////////////////////////////////////////////////////////
    // read port: answer one cycle after the read strobe

    always_comb begin
        rdVal = 16'h0000;
        if (regReq.addr == ADDR_FLAG) begin
            rdVal = {8'h00, flagCtl_r};
        end else if (regReq.addr == ADDR_TCTL) begin
            rdVal = {8'h00, tctl_r};
        end else if (regReq.addr == ADDR_IEN) begin
            // bit 0 is fixed and always reads 1
            rdVal = {8'h00, ien_r, IEN_RST[0]};
        end else if (regReq.addr == ADDR_CNT) begin
            rdVal = cnt_r;
        end else if (regReq.addr == ADDR_CMPA) begin
            rdVal = cmpA_r;
        end else if (regReq.addr == ADDR_CMPB) begin
            rdVal = cmpB_r;
        end else if (regReq.addr == ADDR_CAPA) begin
            rdVal = capA_r;
        end else if (regReq.addr == ADDR_CAPB) begin
            rdVal = capB_r;
        end else if (regReq.addr == ADDR_CAPC) begin
            rdVal = capC_r;
        end else if (regReq.addr == ADDR_CAPD) begin
            rdVal = capD_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wipe) begin
            regRdata <= 16'h0000;
        end else if (regReq.rd) begin
            regRdata <= rdVal;
        end
    end

endmodule : tccs_timer_status

`default_nettype wire

// ==== tb/tccs_timer_status_asserts.sv ====
// Purpose: port-level checks for tccs_timer_status
// Assumes: one clock domain, srst synchronous active high
// Notes:   the counter is not visible here, so flag rises are tied to their causes
`timescale 1ns/100ps
`default_nettype none
module tccs_timer_status_asserts
    import tccs_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic                 clk_sys,
    input wire logic                 srst,
    input wire logic                 lowPower,
    input wire logic                 countTick,
    input wire tccs_pkg::tccs_req_t  regReq,
    input wire logic [15:0]          regRdata,
    input wire tccs_pkg::tccs_pins_t capPins,
    input wire logic [7:1]           irqVec,
    input wire logic                 irqAny
);
////////////////////////////////////////////////////////////////////////////////
    logic [15:0] pinHist_r;
    logic [7:1]  irqPrev_r;
    logic [7:1]  rise;
    logic [3:0]  pinChg;
    logic        flagWr;
    logic        ienWr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    always_ff @(posedge clk_sys) begin
        pinHist_r <= {pinHist_r[11:0], capPins};
        irqPrev_r <= irqVec;
    end
    assign rise   = irqVec & ~irqPrev_r;
    // sync chain delay is 3 edges; one edge of slack on the short side only
    assign pinChg = (pinHist_r[15:12] ^ pinHist_r[11:8]) | (pinHist_r[11:8] ^ pinHist_r[7:4]);
    assign flagWr = regReq.wr && regReq.addr == ADDR_FLAG;
    assign ienWr  = regReq.wr && regReq.addr == ADDR_IEN;
////////////////////////////////////////////////////////////////////////////////
    rst_clears_a: assert property (disable iff (1'b0)
        srst |=> regRdata == 16'h0000 && irqVec == 7'h00)
        else $error("reset left state behind");
    lowpwr_clears_a: assert property (
        lowPower |=> regRdata == 16'h0000 && irqVec == 7'h00)
        else $error("low power left state behind");
    flag_upper_a: assert property (
        regReq.rd && regReq.addr == ADDR_FLAG |=> regRdata[15:8] == 8'h00)
        else $error("flag register upper byte not zero");
    ien_fixed_a: assert property (
        regReq.rd && regReq.addr == ADDR_IEN |=> regRdata[0] && regRdata[15:8] == 8'h00)
        else $error("irq enable fixed bit wrong");
    irq_any_a: assert property (irqAny == (|irqVec))
        else $error("irqAny not the OR of irqVec");
    rd_hold_a: assert property (!regReq.rd && !lowPower |=> $stable(regRdata))
        else $error("read data moved without a read");
    clr_cause_a: assert property (
        (irqPrev_r & ~irqVec) != 7'h00
        |-> $past(flagWr) || $past(ienWr) || $past(lowPower) || $past(srst))
        else $error("irq dropped without a clear write");
    cap_cause_a: assert property (
        (rise[7:4] & ~pinChg) != 4'h0 |-> $past(ienWr))
        else $error("capture flag rose without its pin");
    cmp_cause_a: assert property (
        rise[3:1] != 3'h0
        |-> $past(countTick) || $past(countTick, 2) || $past(regReq.wr, 2) || $past(ienWr))
        else $error("compare or overflow flag rose without cause");
    cap_seen_c: cover property (rise[7:4] != 4'h0);
    cmp_seen_c: cover property (rise[3:2] != 2'h0);
    ovf_seen_c: cover property (rise[1]);
endmodule : tccs_timer_status_asserts

bind tccs_timer_status tccs_timer_status_asserts #(.CNT_W(CNT_W)) u_chk (
    .clk_sys(clk_sys), .srst(srst),
    .lowPower(lowPower), .countTick(countTick), .regReq(regReq), .regRdata(regRdata),
    .capPins(capPins), .irqVec(irqVec), .irqAny(irqAny));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: directed register-level bench for tccs_timer_status
// Assumes: 100 ns clock, inputs change 1 ns after the rising edge
// Notes:   the counter moves only on countTick or a register write, so captured values are known
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tccs_pkg::*;
    logic        clk_sys   = 1'b0;
    logic        srst      = 1'b1;
    logic        lowPower  = 1'b0;
    logic        countTick = 1'b0;
    tccs_req_t   regReq    = '0;
    tccs_pins_t  capPins   = 4'hF;
    logic [15:0] regRdata;
    logic [7:1]  irqVec;
    logic        irqAny;
    logic [15:0] rdVal;
    int          err_total = 0;
    int          n_checks  = 0;
    int          cycles    = 0;
    always #50 clk_sys = ~clk_sys;
    tccs_timer_status uut (.clk_sys(clk_sys), .srst(srst), .lowPower(lowPower),
        .countTick(countTick), .regReq(regReq), .regRdata(regRdata), .capPins(capPins),
        .irqVec(irqVec), .irqAny(irqAny));
////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #1 regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_sys);
        #1 regReq = '0;
        rdVal = regRdata;
    endtask : op
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
        op(1'b0, a, 16'h0000);
        chk(rdVal, exp);
    endtask : rdChk
    task automatic irqChk(input logic [7:1] exp);
        @(posedge clk_sys);
        #1 chk({8'h00, irqAny, irqVec}, {8'h00, |exp, exp});
    endtask : irqChk
    // pulses stay well above the three-clock minimum
    task automatic pin(input int k, input logic v);
        @(posedge clk_sys);
        #1 capPins[3-k] = v;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : pin
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1 countTick = 1'b1;
            @(posedge clk_sys);
            #1 countTick = 1'b0;
        end
    endtask : tick
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        #1 srst = 1'b0;
        rdChk(ADDR_FLAG, 16'h0000);
        rdChk(ADDR_IEN, 16'h0001);
        op(1'b1, ADDR_FLAG, 16'h00FE);
        rdChk(ADDR_FLAG, 16'h0000);
        op(1'b1, ADDR_FLAG, 16'h0001);
        rdChk(ADDR_FLAG, 16'h0001);
        op(1'b1, ADDR_IEN, 16'h00FE);
        for (int k = 0; k < 4; k++) begin
            op(1'b1, ADDR_CNT, 16'(16'h1230 + k));
            pin(k, 1'b0);
            pin(k, 1'b1);
            rdChk(4'(ADDR_CAPA + k), 16'(16'h1230 + k));
        end
        irqChk(7'h78);
        op(1'b1, ADDR_CNT, 16'h4444);
        pin(0, 1'b0);
        pin(0, 1'b1);
        rdChk(ADDR_CAPA, 16'h4444);
        // a zero write before any read of the flags must not clear them
        op(1'b1, ADDR_FLAG, 16'h0001);
        irqChk(7'h78);
        op(1'b1, ADDR_IEN, 16'h0000);
        irqChk(7'h00);
        rdChk(ADDR_FLAG, 16'h00F1);
        op(1'b1, ADDR_IEN, 16'h00FE);
        op(1'b1, ADDR_FLAG, 16'h0071);
        irqChk(7'h38);
        op(1'b1, ADDR_FLAG, 16'h0001);
        irqChk(7'h00);
        op(1'b1, ADDR_TCTL, 16'h000C);
        for (int j = 0; j < 2; j++) begin
            op(1'b1, ADDR_CNT, 16'h1111);
            pin(j, 1'b0);
            pin(j, 1'b1);
            op(1'b1, ADDR_CNT, 16'h2222);
            pin(j, 1'b0);
            pin(j, 1'b1);
            op(1'b1, ADDR_CNT, 16'h3333);
            pin(j + 2, 1'b0);
            pin(j + 2, 1'b1);
            rdChk(4'(ADDR_CAPA + j), 16'h2222);
            rdChk(4'(ADDR_CAPC + j), 16'h1111);
        end
        // rising select on A with falling on C takes both edges of pin A
        op(1'b1, ADDR_TCTL, 16'h008C);
        op(1'b1, ADDR_CNT, 16'h5555);
        pin(0, 1'b0);
        op(1'b1, ADDR_CNT, 16'h6666);
        pin(0, 1'b1);
        rdChk(ADDR_CAPA, 16'h6666);
        rdChk(ADDR_CAPC, 16'h5555);
        irqChk(7'h78);
        rdChk(ADDR_FLAG, 16'h00F1);
        op(1'b1, ADDR_FLAG, 16'h0000);
        op(1'b1, ADDR_CMPA, 16'h0005);
        op(1'b1, ADDR_CMPB, 16'h0003);
        op(1'b1, ADDR_CNT, 16'h0000);
        tick(3);
        irqChk(7'h02);
        tick(3);
        irqChk(7'h06);
        rdChk(ADDR_CNT, 16'h0006);
        rdChk(ADDR_FLAG, 16'h000C);
        op(1'b1, ADDR_FLAG, 16'h0001);
        op(1'b1, ADDR_CNT, 16'h0000);
        tick(7);
        rdChk(ADDR_CNT, 16'h0001);
        irqChk(7'h06);
        rdChk(ADDR_FLAG, 16'h000D);
        op(1'b1, ADDR_FLAG, 16'h0000);
        op(1'b1, ADDR_CNT, 16'hFFFE);
        tick(2);
        irqChk(7'h01);
        rdChk(ADDR_CNT, 16'h0000);
        rdChk(ADDR_FLAG, 16'h0002);
        op(1'b1, ADDR_CNT, 16'hFFFF);
        // overflow event and the clear of that flag land on the same edge
        @(posedge clk_sys);
        #1 countTick = 1'b1;
        regReq = '{wr: 1'b1, rd: 1'b0, addr: ADDR_FLAG, wdata: 16'h0000};
        @(posedge clk_sys);
        #1 countTick = 1'b0;
        regReq = '0;
        irqChk(7'h01);
        rdChk(ADDR_FLAG, 16'h0002);
        @(posedge clk_sys);
        #1 lowPower = 1'b1;
        @(posedge clk_sys);
        #1 lowPower = 1'b0;
        irqChk(7'h00);
        rdChk(ADDR_FLAG, 16'h0000);
        rdChk(ADDR_IEN, 16'h0001);
        conclude();
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            conclude();
        end
    end
endmodule : tb_top
`default_nettype wire
